// *** verification/ebp_mem_model.sv ***
// far side of the bus port: address latch, byte-wide memory, read drivers
// assumes the bench resolves the lines and marks eight-bit cycles on narrow
`timescale 1ns/100ps
module ebp_mem_model (
  input wire logic clk,
  input wire logic [15:0] lines,
  input wire logic ale,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic narrow,
  output logic drv_en,
  output logic [15:0] drv
);
  logic [15:0] la_q = 16'h0;
  logic [15:0] wa;
  byte unsigned mem [int];

  // word parts ignore the lowest address bit; even and odd bytes sit apart
  assign wa = {la_q[15:1], 1'b0};
  assign drv_en = !rd_b;

  // latch takes the address while the strobe is high, so data sees it steady
  always @(posedge clk) begin
    if (ale) la_q <= lines;
    if (!wr_b && narrow) mem[la_q] = lines[7:0];
    else if (!wr_b) begin
      mem[wa] = lines[7:0];
      mem[wa + 16'h1] = lines[15:8];
    end
    // narrow parts own only the low lane; the top lane shows the inverted high byte of the latched address
    drv <= narrow ? {~la_q[15:8], mem[la_q]} : {mem[wa + 16'h1], mem[wa]};
  end
endmodule // ebp_mem_model

// *** verification/tb.sv ***
// self-checking bench: width modes, port map, reset pin pulse
// assumes ebp_bus_port and ebp_mem_model; inputs change at falling edges
`timescale 1ns/100ps
module tb;
  logic clk = 0, rst_b = 0, req = 0, we = 0, bt = 0, bws = 1, ea = 0, rreq = 0, nar = 0, ce = 1;
  logic [1:0] mode = 2'h0;
  logic [15:0] addr = 16'h0, wd = 16'h0, rd, lo, pd, lines, last = 16'h0, a, d;
  logic ack, oe, ale, rd_b, wr_b, poe, cres, pin_o, mdrv;
  logic [31:0] lf = 32'h220F;
  int errors = 0, total_checks = 0, lat, k;
  byte unsigned bm [int];

  always #2.5 clk = ~clk;

  // released lines show the inverse of their last level, never a stale copy
  assign lines = oe ? lo : (mdrv ? pd : ~last);
  always @(posedge clk) last <= lines;

  ebp_bus_port dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .bus_mode(mode), .req(req),
    .req_we(we), .req_byte(bt), .req_addr(addr), .req_wdata(wd), .ack(ack), .rdata(rd),
    .muxed_addr_data_lines_i(lines), .muxed_addr_data_lines_o(lo),
    .muxed_addr_data_lines_oe(oe), .ale(ale), .rd_b(rd_b), .wr_b(wr_b),
    .bus_width_select(bws), .external_access_select(ea),
    .reset_pin_i(poe ? pin_o : 1'b1), .reset_pin_o(pin_o), .reset_pin_oe(poe),
    .reset_req(rreq), .core_reset(cres));

  ebp_mem_model far_u (.clk(clk), .lines(lines), .ale(ale), .rd_b(rd_b), .wr_b(wr_b),
    .narrow(nar), .drv_en(mdrv), .drv(pd));

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one request held for a single cycle, then answer counted in cycles from the take
  task automatic acc(input logic w, input logic b, input logic [15:0] ad,
                     input logic [15:0] dt, input int el);
    req = 1;
    we = w;
    bt = b;
    addr = ad;
    wd = dt;
    @(negedge clk);
    req = 0;
    lat = 1;
    while (ack !== 1'b1 && lat < 40) begin
      @(negedge clk);
      lat++;
    end
    chk(lat[15:0], el[15:0]);
    if (lat >= 40) complete_run;
    @(negedge clk);
  endtask

  // address phase shows the address above bit 0; read data phase has the lines released
  always @(negedge clk) begin
    if (rst_b && ale) chk(lines | 16'h1, addr | 16'h1);
    if (rst_b && !rd_b) chk({15'h0, oe}, 16'h0);
  end

  initial begin
    repeat (10) @(negedge clk);
    chk({11'h0, oe, ale, rd_b, wr_b, poe}, 16'h0006);
    rst_b = 1;
    repeat (4) @(negedge clk);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      repeat (4) begin
        lf = nx(lf);
        a = {lf[15], 3'h0, lf[11:1], 1'b0};
        d = lf[31:16];
        bws = lf[3];
        nar = (m == 1) || (m > 1 && !lf[3]);
        repeat (3) @(negedge clk);
        acc(1, 0, a, d, nar ? 13 : 7);
        bm[a] = d[7:0];
        bm[a + 1] = d[15:8];
        if (nar) begin
          acc(1, 1, a | 16'h1, {8'h0, ~d[15:8]}, 7);
          bm[a + 1] = ~d[15:8];
        end
        acc(0, 0, a, 16'h0, nar ? 13 : 7);
        chk(rd, {bm[a + 1], bm[a]});
        acc(0, 1, a | 16'h1, 16'h0, 7);
        chk(rd, {8'h0, bm[a + 1]});
      end
    end
    mode = 2'h0;
    nar = 0;
    ea = 1;
    // select sync, then driven port levels through the line sync, before the first port read
    repeat (6) @(negedge clk);
    acc(0, 0, 16'h1FFE, 16'h0, 1);
    chk(rd, 16'hFFFF);
    acc(1, 0, 16'h1FFE, 16'h5AC3, 1);
    repeat (5) @(negedge clk);
    chk(lines, 16'h5AC3);
    acc(1, 1, 16'h1FFF, 16'h0096, 1);
    repeat (5) @(negedge clk);
    acc(0, 1, 16'h1FFF, 16'h0, 1);
    chk(rd, 16'h0096);
    acc(0, 0, 16'h1FFE, 16'h0, 1);
    chk(rd, 16'h96C3);
    ea = 0;
    repeat (4) @(negedge clk);
    acc(1, 0, 16'h1FFE, 16'h1234, 7);
    acc(0, 0, 16'h1FFE, 16'h0, 7);
    chk(rd, 16'h1234);
    // clock enable low freezes the pulse counter, so the request waits
    rreq = 1;
    ce = 0;
    repeat (4) @(negedge clk);
    chk({15'h0, poe}, 16'h0000);
    ce = 1;
    @(negedge clk);
    rreq = 0;
    // the first pulse cycle is already showing at this edge
    lat = int'(poe);
    k = int'(cres);
    repeat (30) begin
      @(negedge clk);
      lat += int'(poe);
      k += int'(cres);
    end
    chk(lat[15:0], 16'h0010);
    chk({15'h0, k > 0}, 16'h0001);
    complete_run;
  end
endmodule // tb

// *** verilog/ebp_bus_port.sv ***
// multiplexed address/data external bus port with shared i/o ports and reset pin
// assumes a single core requester on clk; pins are asynchronous and synchronised here
`timescale 1ns/100ps
`include "ebp_defs.svh"

// How it works
// - address and data share the sixteen multiplexed lines within each access
// - a full sixteen-bit address is driven in every width mode
// - standard mode moves data over all sixteen lines
// - fixed narrow mode moves every datum over the low eight lines
// - dynamic mode picks eight or sixteen bits per external cycle
// - outside decode drives width select; low selects an eight-bit cycle
// - the bus lines double as two i/o ports while no bus cycle runs
// - with access select high, the two port addresses hit the port latches
// - with access select low, the two port addresses go to external memory
// - reset pin is sensed and also pulled low, so sources must be wired-or
module ebp_bus_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [1:0] bus_mode,
  input wire logic req,
  input wire logic req_we,
  input wire logic req_byte,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic ack,
  output logic [15:0] rdata,
  input wire logic [15:0] muxed_addr_data_lines_i,
  output logic [15:0] muxed_addr_data_lines_o,
  output logic muxed_addr_data_lines_oe,
  output logic ale,
  output logic rd_b,
  output logic wr_b,
  input wire logic bus_width_select,
  input wire logic external_access_select,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic reset_req,
  output logic core_reset
);

  ebp_pkg::ebp_reg_t s_q, s_d;
  logic [15:0] lines_s;
  logic bw_s, ea_s, rpin_s;
  logic take, port_hit, beat_narrow;

  ebp_sync #(.W(16)) u_lines_sync (.clk(clk), .rst_b(rst_b), .ce(ce),
    .d(muxed_addr_data_lines_i), .q(lines_s));
  ebp_sync #(.W(3)) u_pin_sync (.clk(clk), .rst_b(rst_b), .ce(ce),
    .d({bus_width_select, external_access_select, reset_pin_i}),
    .q({bw_s, ea_s, rpin_s}));

  // port addresses differ only in the lowest address bit
  function automatic logic is_port(input logic [15:0] a);
    is_port = (a[15:1] == 15'(`EBP_PORT_LO_ADDR >> 1));
  endfunction

  // write data placed on the lines for one beat
  function automatic logic [15:0] wr_lanes(input logic [15:0] a, input logic [15:0] d,
                                           input logic bt, input logic nar, input logic sec);
    if (nar) begin
      wr_lanes = {a[15:8], sec ? d[15:8] : d[7:0]};
    end else if (bt) begin
      wr_lanes = {d[7:0], d[7:0]};
    end else begin
      wr_lanes = d;
    end
  endfunction

  assign take = (s_q.st == ebp_pkg::EBP_IDLE) && req;
  assign port_hit = ea_s && is_port(req_addr);
  // width of this beat decided at the close of the address phase
  always_comb begin
    unique case (bus_mode)
      `EBP_MODE_W16: beat_narrow = 1'b0;
      `EBP_MODE_W8: beat_narrow = 1'b1;
      default: beat_narrow = !bw_s;
    endcase
  end

  // next state of the whole port
  always_comb begin
    s_d = s_q;
    if (s_q.rst_cnt != 5'h00) begin
      s_d.rst_cnt = s_q.rst_cnt - 5'h01;
    end else if (reset_req) begin
      s_d.rst_cnt = 5'(`EBP_RSTOUT_CYC);
    end
    unique case (s_q.st)
      ebp_pkg::EBP_IDLE: begin
        s_d.ale = 1'b0;
        // idle lines carry the port latches only when ports are live
        s_d.lines_o = {s_q.port_hi, s_q.port_lo};
        s_d.lines_oe = ea_s;
        if (take) begin
          s_d.addr = req_addr;
          s_d.wdata = req_wdata;
          s_d.we = req_we;
          s_d.byte_acc = req_byte;
          s_d.second = 1'b0;
          if (port_hit) begin
            // port access never starts a bus cycle
            s_d.st = ebp_pkg::EBP_DONE;
            s_d.rdata = req_byte ? {8'h00, req_addr[0] ? lines_s[15:8] : lines_s[7:0]}
                                 : lines_s;
            if (req_we && (!req_byte || !req_addr[0])) begin
              s_d.port_lo = req_wdata[7:0];
            end
            if (req_we && (!req_byte || req_addr[0])) begin
              s_d.port_hi = req_byte ? req_wdata[7:0] : req_wdata[15:8];
            end
          end else begin
            s_d.st = ebp_pkg::EBP_ADDR;
            s_d.cnt = 5'(`EBP_ADDR_CYC - 1);
            s_d.lines_o = req_addr;
            s_d.lines_oe = 1'b1;
            s_d.ale = 1'b1;
          end
        end
      end
      ebp_pkg::EBP_ADDR: begin
        // strobe falls one cycle before the address leaves the lines
        s_d.ale = 1'b0;
        s_d.cnt = s_q.cnt - 5'h01;
        if (s_q.cnt == 5'h00) begin
          s_d.st = ebp_pkg::EBP_DATA;
          s_d.cnt = 5'(`EBP_DATA_CYC - 1);
          s_d.narrow = beat_narrow;
          s_d.lines_oe = s_q.we;
          s_d.lines_o = wr_lanes(s_q.addr, s_q.wdata, s_q.byte_acc, beat_narrow, s_q.second);
          s_d.rd_b = s_q.we;
          s_d.wr_b = !s_q.we;
        end
      end
      ebp_pkg::EBP_DATA: begin
        s_d.cnt = s_q.cnt - 5'h01;
        if (s_q.cnt == 5'h00) begin
          s_d.rd_b = 1'b1;
          s_d.wr_b = 1'b1;
          s_d.lines_oe = 1'b0;
          if (s_q.narrow && s_q.second) begin
            s_d.rdata[15:8] = lines_s[7:0];
          end else if (s_q.narrow) begin
            s_d.rdata = {8'h00, lines_s[7:0]};
          end else if (s_q.byte_acc) begin
            s_d.rdata = {8'h00, s_q.addr[0] ? lines_s[15:8] : lines_s[7:0]};
          end else begin
            s_d.rdata = lines_s;
          end
          if (s_q.narrow && !s_q.byte_acc && !s_q.second) begin
            // narrow word: second byte beat at the odd address
            s_d.st = ebp_pkg::EBP_ADDR;
            s_d.second = 1'b1;
            s_d.addr = s_q.addr | 16'h0001;
            s_d.cnt = 5'(`EBP_ADDR_CYC - 1);
            s_d.lines_o = s_q.addr | 16'h0001;
            s_d.lines_oe = 1'b1;
            s_d.ale = 1'b1;
          end else begin
            s_d.st = ebp_pkg::EBP_DONE;
          end
        end
      end
      ebp_pkg::EBP_DONE: begin
        s_d.st = ebp_pkg::EBP_IDLE;
      end
    endcase
  end

  // one register for all state; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: ebp_pkg::EBP_IDLE, addr: 16'h0000, wdata: 16'h0000, we: 1'b0,
               byte_acc: 1'b0, narrow: 1'b0, second: 1'b0, cnt: 5'h00, rdata: 16'h0000,
               lines_o: 16'h0000, lines_oe: 1'b0, ale: 1'b0, rd_b: 1'b1, wr_b: 1'b1,
               port_lo: `EBP_PORT_RST, port_hi: `EBP_PORT_RST, rst_cnt: 5'h00};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ack = (s_q.st == ebp_pkg::EBP_DONE);
  assign rdata = s_q.rdata;
  assign muxed_addr_data_lines_o = s_q.lines_o;
  assign muxed_addr_data_lines_oe = s_q.lines_oe;
  assign ale = s_q.ale;
  assign rd_b = s_q.rd_b;
  assign wr_b = s_q.wr_b;
  // open-drain style: only ever pulls low, so it can share a wired-or line
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = (s_q.rst_cnt != 5'h00);
  assign core_reset = !rpin_s;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  addr_drive_a: assert property (s_q.st == ebp_pkg::EBP_ADDR |-> s_q.lines_oe)
    else $error("address phase without driven lines");
  full_addr_a: assert property (s_q.st == ebp_pkg::EBP_ADDR |-> s_q.lines_o == s_q.addr)
    else $error("address phase lines differ from address");
  ale_first_a: assert property (ce && take && !port_hit |=> ale ##1 !ale && s_q.lines_oe)
    else $error("latch strobe not at start of cycle");
  read_release_a: assert property (s_q.st == ebp_pkg::EBP_DATA && !s_q.we |-> !s_q.lines_oe)
    else $error("read data phase still drives lines");
  wide_mode_a: assert property (s_q.st == ebp_pkg::EBP_DATA && bus_mode == `EBP_MODE_W16
    |-> !s_q.narrow)
    else $error("narrow beat in sixteen-bit mode");
  narrow_mode_a: assert property (s_q.st == ebp_pkg::EBP_DATA && bus_mode == `EBP_MODE_W8
    |-> s_q.narrow)
    else $error("wide beat in eight-bit mode");
  dyn_width_a: assert property (ce && s_q.st == ebp_pkg::EBP_ADDR && s_q.cnt == 5'h00
    && bus_mode == `EBP_MODE_DYN |=> s_q.narrow == !$past(bw_s))
    else $error("dynamic width not taken from select");
  port_local_a: assert property (ce && take && port_hit |=> ack && !ale && rd_b && wr_b)
    else $error("port access reached the bus");
  port_mem_a: assert property (ce && take && !ea_s && is_port(req_addr)
    |=> s_q.st == ebp_pkg::EBP_ADDR)
    else $error("port address not sent to memory");
  rst_pulse_a: assert property (ce && reset_req && s_q.rst_cnt == 5'h00
    |=> reset_pin_oe [*8])
    else $error("reset pin pulse too short");

  narrow_word_c: cover property (s_q.st == ebp_pkg::EBP_DATA && s_q.narrow && s_q.second);
  port_write_c: cover property (take && port_hit && req_we);
  reset_out_c: cover property ($rose(reset_pin_oe));

endmodule // ebp_bus_port

// *** verilog/ebp_defs.svh ***
// constants of the multiplexed external bus port: timing, port addresses, reset values
// assumes a 200 MHz core clock; included by the bus port module only, not by ebp_pkg
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

`define EBP_CLK_NS 5
`define EBP_ADDR_NS 10
`define EBP_DATA_NS 20
`define EBP_RSTOUT_NS 80
// least times round up to whole cycles
`define EBP_ADDR_CYC ((`EBP_ADDR_NS + `EBP_CLK_NS - 1) / `EBP_CLK_NS)
`define EBP_DATA_CYC ((`EBP_DATA_NS + `EBP_CLK_NS - 1) / `EBP_CLK_NS)
`define EBP_RSTOUT_CYC ((`EBP_RSTOUT_NS + `EBP_CLK_NS - 1) / `EBP_CLK_NS)

`define EBP_PORT_LO_ADDR 16'h1FFE
`define EBP_PORT_HI_ADDR 16'h1FFF
`define EBP_PORT_RST 8'hFF
`define EBP_MODE_W16 2'h0
`define EBP_MODE_W8 2'h1
`define EBP_MODE_DYN 2'h2

`endif

// *** verilog/ebp_pkg.sv ***
// types of the multiplexed external bus port
// assumes ebp_defs.svh for widths of counters
package ebp_pkg;

  // gray codes along idle, address, data, done
  typedef enum logic [1:0] {
    EBP_IDLE = 2'h0,
    EBP_ADDR = 2'h1,
    EBP_DATA = 2'h3,
    EBP_DONE = 2'h2
  } ebp_state_t;

  typedef struct packed {
    ebp_state_t st;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic we;
    logic byte_acc;
    logic narrow;
    logic second;
    logic [4:0] cnt;
    logic [15:0] rdata;
    logic [15:0] lines_o;
    logic lines_oe;
    logic ale;
    logic rd_b;
    logic wr_b;
    logic [7:0] port_lo;
    logic [7:0] port_hi;
    logic [4:0] rst_cnt;
  } ebp_reg_t;

endpackage

// *** verilog/ebp_sync.sv ***
// two-flop synchroniser for pin levels entering the core clock domain
// assumes inputs are quasi-static levels; multi-bit values are only sampled when settled
`timescale 1ns/100ps
module ebp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // ebp_sync
